// ==== logic/i2cm_status.sv ====
// Purpose: Status, flags and interrupt of an I2C bus master, on APB
// Assumes: The master engine runs on ref_clk; bus lines are asynchronous
// Notes: Control register doubles as the interrupt mask
//
// Implementation choice: register access over APB.
`default_nettype none

module i2cm_status (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic engine_busy,
	input wire logic engine_dir_read,
	input wire logic addr_nak_evt,
	input wire logic data_nak_evt,
	input wire logic arb_lost_evt,
	input wire logic own_stop_evt,
	input wire logic tx_empty_end_evt,
	input wire logic tx_pop,
	output logic [7:0] tx_byte,
	output logic tx_byte_valid,
	input wire logic rx_push,
	input wire logic [7:0] rx_byte,
	output logic master_clk_en,
	output logic irq
);
	// ------------------------------------------------------------
	// Line filters and bus condition detection
	// ------------------------------------------------------------
	logic [1:0] line_raw;
	logic [1:0] line_filt;
	logic [1:0] line_prev;
	logic bus_busy;
	assign line_raw = {scl_in, sda_in};

	// One filter per line; index 1 is the clock line
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_line
			i2cm_line_filter u_filt (
				.ref_clk(ref_clk),
				.rst_n(rst_n),
				.line_in(line_raw[gi]),
				.line_filtered(line_filt[gi])
			);
		end
	endgenerate

	wire clock_line_filtered = line_filt[1];
	wire data_line_filtered = line_filt[0];
	// Data edge while clock stays high marks start or stop
	// Both levels come filtered, so a glitch cannot fake a condition
	wire clk_high_both = clock_line_filtered && line_prev[1];
	wire start_det = clk_high_both && line_prev[0] && !data_line_filtered;
	wire stop_det = clk_high_both && !line_prev[0] && data_line_filtered;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			line_prev <= 2'h3;
			bus_busy <= 1'b0;
		end else begin
			line_prev <= line_filt;
			if (start_det) begin
				bus_busy <= 1'b1;
			end else if (stop_det) begin
				bus_busy <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------
	// Only the write-mask bits are stored; the rest read back zero
	logic [15:0] ctrl;
	wire master_enable_bit = ctrl[i2cm_pkg::CT_MASTER_ENABLE_BIT];
	wire completion_irq_en = ctrl[i2cm_pkg::CT_IEN_CMP];
	wire nak_irq_en = ctrl[i2cm_pkg::CT_IEN_ACK];
	wire arbitration_irq_en = ctrl[i2cm_pkg::CT_IEN_ARBITRATION_LOST_FLAG];
	wire tx_request_irq_en = ctrl[i2cm_pkg::CT_IEN_TX];
	wire rx_request_irq_en = ctrl[i2cm_pkg::CT_IEN_RX];

	// Disabled master: no clock to the engine, its events are ignored
	assign master_clk_en = master_enable_bit;

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	wire setup = psel && !penable;
	wire done = psel && penable && pready;
	// Whole-word compare: a partial decode would alias other registers
	function automatic logic reg_hit(input logic [31:0] addr, input logic [31:0] base);
		return addr == base;
	endfunction : reg_hit

	wire hit_ctrl = reg_hit(paddr, i2cm_pkg::ADDR_CTRL);
	wire hit_status = reg_hit(paddr, i2cm_pkg::ADDR_STATUS);
	wire hit_rx = reg_hit(paddr, i2cm_pkg::ADDR_RX);
	wire hit_tx = reg_hit(paddr, i2cm_pkg::ADDR_TX);
	wire hit_any = hit_ctrl || hit_status || hit_rx || hit_tx;
	wire wr_done = done && pwrite && hit_any;
	wire rd_done = done && !pwrite && hit_any;

	// Answer tracker: every setup is answered in the very next cycle,
	// so the slave never inserts a wait state
	typedef enum logic [1:0] {
		APB_IDLE = 2'b00,
		APB_ANSWER = 2'b01
	} i2cm_apb_e;
	i2cm_apb_e apb_state;
	i2cm_apb_e next_apb_state;

	always_comb begin
		case (apb_state)
			APB_IDLE: begin
				next_apb_state = setup ? APB_ANSWER : APB_IDLE;
			end
			APB_ANSWER: begin
				// A setup right after an answer is taken as well
				next_apb_state = setup ? APB_ANSWER : APB_IDLE;
			end
			default: begin
				next_apb_state = APB_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------
	// FIFOs
	// ------------------------------------------------------------
	i2cm_fifo_if tx_if ();
	i2cm_fifo_if rx_if ();

	i2cm_fifo2 u_tx_fifo (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.port(tx_if)
	);
	i2cm_fifo2 u_rx_fifo (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.port(rx_if)
	);

	assign tx_if.push = wr_done && hit_tx;
	assign tx_if.push_data = pwdata[7:0];
	// Engine pops and pushes are dropped while the master is off
	assign tx_if.pop = tx_pop && master_enable_bit;
	// The head byte stands on tx_byte until the engine pops it
	assign tx_byte = tx_if.head;
	assign tx_byte_valid = !tx_if.empty;
	assign rx_if.push = rx_push && master_enable_bit;
	assign rx_if.push_data = rx_byte;
	assign rx_if.pop = rd_done && hit_rx;

	// ------------------------------------------------------------
	// Status word
	// ------------------------------------------------------------
	logic [15:0] flags;
	logic [15:0] next_flags;
	logic [15:0] flag_set;
	logic [15:0] flag_clr;
	logic [15:0] status;
	logic [15:0] rd_snap;
	logic [1:0] tx_fifo_level;

	wire master_engine_busy = engine_busy && master_enable_bit;
	wire rx_request = !rx_if.empty;
	wire tx_request = !engine_dir_read && !tx_if.full;

	// Count to level code: one byte held reads 10, not a binary count
	function automatic logic [1:0] level_code(input logic [1:0] cnt);
		logic [1:0] code;
		case (cnt)
			2'h0: code = i2cm_pkg::LVL_EMPTY;
			2'h1: code = i2cm_pkg::LVL_ONE;
			default: code = i2cm_pkg::LVL_FULL;
		endcase
		return code;
	endfunction : level_code

	assign tx_fifo_level = level_code(tx_if.count);

	// ------------------------------------------------------------
	// Flag events
	// ------------------------------------------------------------
	// A gated-off engine may still pulse; its events are dropped here
	wire ev_tx_underflow = tx_empty_end_evt && master_enable_bit
		&& tx_request_irq_en;
	wire ev_own_stop = own_stop_evt && master_enable_bit;
	// Only the receive side reports a dropped push; the sender polls the level
	wire ev_rx_overflow = rx_if.push && rx_if.full;
	wire ev_done = stop_det && master_enable_bit;
	wire ev_data_nak = data_nak_evt && master_enable_bit;
	wire ev_arb_lost = arb_lost_evt && master_enable_bit;
	wire ev_addr_nak = addr_nak_evt && master_enable_bit;

	always_comb begin
		flag_set = 16'h0000;
		flag_set[i2cm_pkg::ST_TXUF] = ev_tx_underflow;
		flag_set[i2cm_pkg::ST_OWNSTOP] = ev_own_stop;
		flag_set[i2cm_pkg::ST_RXOF] = ev_rx_overflow;
		flag_set[i2cm_pkg::ST_DONE] = ev_done;
		flag_set[i2cm_pkg::ST_DNAK] = ev_data_nak;
		flag_set[i2cm_pkg::ST_ARBITRATION_LOST_FLAG] = ev_arb_lost;
		flag_set[i2cm_pkg::ST_ANAK] = ev_addr_nak;
	end

	// Read clears only what the reader saw; a write of one clears too
	wire [15:0] clr_by_read = (rd_done && hit_status) ? rd_snap : 16'h0000;
	wire [15:0] clr_by_write = (wr_done && hit_status) ? pwdata[15:0] : 16'h0000;
	assign flag_clr = clr_by_read | clr_by_write;
	// Set is applied after clear so a same-cycle event survives
	assign next_flags = ((flags & ~flag_clr) | flag_set) & i2cm_pkg::RC_MASK;

	// Live bits are merged here, never stored, so no read clears them
	always_comb begin
		status = flags;
		status[i2cm_pkg::ST_RSVD] = 1'b0;
		status[i2cm_pkg::ST_SCL] = clock_line_filtered;
		status[i2cm_pkg::ST_SDA] = data_line_filtered;
		status[i2cm_pkg::ST_BUSBUSY] = bus_busy;
		status[i2cm_pkg::ST_MASTER_ENGINE_BUSY] = master_engine_busy;
		status[i2cm_pkg::ST_RXREQ] = rx_request;
		status[i2cm_pkg::ST_TXREQ] = tx_request;
		status[i2cm_pkg::ST_TXLVL +: 2] = tx_fifo_level;
	end

	// ------------------------------------------------------------
	// Interrupt
	// ------------------------------------------------------------
	// Own-stop and overflow flags never reach the interrupt
	wire irq_done = flags[i2cm_pkg::ST_DONE] && completion_irq_en;
	wire irq_nak = (flags[i2cm_pkg::ST_DNAK] || flags[i2cm_pkg::ST_ANAK]) && nak_irq_en;
	wire irq_arbitration_lost_flag = flags[i2cm_pkg::ST_ARBITRATION_LOST_FLAG] && arbitration_irq_en;
	// Requests are levels, not flags: they hold irq until serviced
	wire irq_tx = tx_request && tx_request_irq_en;
	wire irq_rx = rx_request && rx_request_irq_en;
	assign irq = irq_done || irq_nak || irq_arbitration_lost_flag || irq_tx || irq_rx;

	// ------------------------------------------------------------
	// Registers and APB read path
	// ------------------------------------------------------------
	wire [15:0] rd_mux = hit_ctrl ? (ctrl & i2cm_pkg::CTRL_WMASK) :
		hit_status ? status :
		hit_rx ? {8'h00, rx_if.head} :
		hit_tx ? {8'h00, tx_if.head} : 16'h0000;

	// Read data is captured in setup so prdata comes from a flop; the
	// snapshot also bounds what a clearing read may wipe out
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			// Master gated off and every interrupt masked
			ctrl <= i2cm_pkg::RST_CTRL;
			flags <= 16'h0000;
			rd_snap <= 16'h0000;
			prdata <= 32'h0000_0000;
			apb_state <= APB_IDLE;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			flags <= next_flags;
			apb_state <= next_apb_state;
			pready <= (next_apb_state == APB_ANSWER);
			if (setup) begin
				rd_snap <= rd_mux & i2cm_pkg::RC_MASK;
				prdata <= pwrite ? 32'h0000_0000 : {16'h0000, rd_mux};
				pslverr <= !hit_any;
			end
			if (wr_done && hit_ctrl) begin
				ctrl <= pwdata[15:0] & i2cm_pkg::CTRL_WMASK;
			end
		end
	end
endmodule : i2cm_status

`default_nettype wire

// ==== logic/i2cm_pkg.sv ====
// Purpose: Shared constants for the I2C master status block
// Assumes: 200 MHz ref_clk, APB with 32-bit data
// Notes: Byte addresses are the full printed addresses
`default_nettype none

package i2cm_pkg;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [31:0] ADDR_CTRL = 32'h4000_3400;
	localparam logic [31:0] ADDR_STATUS = 32'h4000_3404;
	localparam logic [31:0] ADDR_RX = 32'h4000_3408;
	localparam logic [31:0] ADDR_TX = 32'h4000_340c;
	localparam logic [15:0] RST_CTRL = 16'h0000;
	localparam logic [15:0] RST_STATUS = 16'h6000;
	localparam logic [15:0] CTRL_WMASK = 16'h01f1;
	localparam logic [15:0] RC_MASK = 16'h1bb0;

	// ------------------------------------------------------------
	// Status field positions
	// ------------------------------------------------------------
	localparam int ST_RSVD = 15;
	localparam int ST_SCL = 14;
	localparam int ST_SDA = 13;
	localparam int ST_TXUF = 12;
	localparam int ST_OWNSTOP = 11;
	localparam int ST_BUSBUSY = 10;
	localparam int ST_RXOF = 9;
	localparam int ST_DONE = 8;
	localparam int ST_DNAK = 7;
	localparam int ST_MASTER_ENGINE_BUSY = 6;
	localparam int ST_ARBITRATION_LOST_FLAG = 5;
	localparam int ST_ANAK = 4;
	localparam int ST_RXREQ = 3;
	localparam int ST_TXREQ = 2;
	localparam int ST_TXLVL = 0;

	// ------------------------------------------------------------
	// Control field positions (also the interrupt mask)
	// ------------------------------------------------------------
	localparam int CT_IEN_CMP = 8;
	localparam int CT_IEN_ACK = 7;
	localparam int CT_IEN_ARBITRATION_LOST_FLAG = 6;
	localparam int CT_IEN_TX = 5;
	localparam int CT_IEN_RX = 4;
	localparam int CT_MASTER_ENABLE_BIT = 0;

	// ------------------------------------------------------------
	// Transmit FIFO level codes
	// ------------------------------------------------------------
	localparam logic [1:0] LVL_EMPTY = 2'h0;
	localparam logic [1:0] LVL_ONE = 2'h2;
	localparam logic [1:0] LVL_FULL = 2'h3;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 5;
	localparam int GLITCH_NS = 50;
	localparam int FILT_CYC = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FIFO_DEPTH = 2;
	localparam int DATA_W = 8;
endpackage : i2cm_pkg

`default_nettype wire

// ==== logic/i2cm_fifo_if.sv ====
// Purpose: Carrier between the status block and its two-byte FIFOs
// Assumes: One clock domain
// Notes: count runs 0..2
`default_nettype none

interface i2cm_fifo_if;
	logic push;
	logic [7:0] push_data;
	logic pop;
	logic [7:0] head;
	logic [1:0] count;
	logic full;
	logic empty;
	modport store (input push, input push_data, input pop,
		output head, output count, output full, output empty);
	modport user (output push, output push_data, output pop,
		input head, input count, input full, input empty);
endinterface : i2cm_fifo_if

`default_nettype wire

// ==== logic/i2cm_fifo2.sv ====
// Purpose: Two-entry byte FIFO in flip-flops
// Assumes: Push when full is dropped; pop when empty is ignored
// Notes: Caller sees full to flag an overflow
`default_nettype none

module i2cm_fifo2 (
	input wire logic ref_clk,
	input wire logic rst_n,
	i2cm_fifo_if.store port
);
	logic [7:0] mem [0:1];
	logic wr_ptr;
	logic rd_ptr;
	logic [1:0] cnt;
	wire do_push = port.push && (cnt != 2'h2);
	wire do_pop = port.pop && (cnt != 2'h0);

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			cnt <= 2'h0;
			mem[0] <= 8'h00;
			mem[1] <= 8'h00;
		end else begin
			if (do_push) begin
				mem[wr_ptr] <= port.push_data;
				wr_ptr <= ~wr_ptr;
			end
			if (do_pop) begin
				rd_ptr <= ~rd_ptr;
			end
			cnt <= cnt + {1'b0, do_push} - {1'b0, do_pop};
		end
	end

	assign port.head = mem[rd_ptr];
	assign port.count = cnt;
	assign port.full = (cnt == 2'h2);
	assign port.empty = (cnt == 2'h0);
endmodule : i2cm_fifo2

`default_nettype wire

// ==== logic/i2cm_line_filter.sv ====
// Purpose: Synchronise and glitch-filter one bus line
// Assumes: Line idles high through its pull-up
// Notes: A new level must hold FILT_CYC cycles before it is passed on
`default_nettype none

module i2cm_line_filter (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic line_in,
	output logic line_filtered
);
	logic meta;
	logic sync;
	logic [7:0] hold_cnt;
	wire differs = (sync != line_filtered);
	wire settled = (hold_cnt == 8'(i2cm_pkg::FILT_CYC - 1));

	// Reset to 1: an undriven line is pulled high
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			meta <= 1'b1;
			sync <= 1'b1;
			hold_cnt <= 8'h00;
			line_filtered <= 1'b1;
		end else begin
			meta <= line_in;
			sync <= meta;
			hold_cnt <= (differs && !settled) ? hold_cnt + 8'h01 : 8'h00;
			if (differs && settled) begin
				line_filtered <= sync;
			end
		end
	end
endmodule : i2cm_line_filter

`default_nettype wire

// ==== testbench/i2cm_status_props.sv ====
// Purpose: Port-level properties of the status block
// Assumes: Zero-wait APB, flags one edge after an event
// Notes: Bound to the design after the module
`default_nettype none

module i2cm_status_props (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic engine_dir_read,
	input wire logic addr_nak_evt,
	input wire logic data_nak_evt,
	input wire logic arb_lost_evt,
	input wire logic tx_byte_valid,
	input wire logic master_clk_en
);
	logic [1:0] last_lines;
	logic [4:0] hold;
	logic [4:0] next_hold;
	wire setup = psel && !penable;
	wire rd_st = setup && !pwrite && paddr == i2cm_pkg::ADDR_STATUS;
	wire mapped = paddr[31:4] == 28'h4000340 && paddr[1:0] == 2'h0;
	assign next_hold = (last_lines != {scl_in, sda_in}) ? 5'h0 : hold + {4'h0, hold != 5'h1f};
	// Counts how long both raw lines have stood still
	always_ff @(posedge ref_clk) begin
		last_lines <= {scl_in, sda_in};
		hold <= rst_n ? next_hold : 5'h0;
	end
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	// The status read may come one or two cycles after the event
	sequence s_ev(e);
		e && master_clk_en ##[1:2] rd_st;
	endsequence
	property p_rdy;
		setup |=> pready ##1 !pready;
	endproperty
	property p_err;
		setup && !mapped |=> pready && pslverr && prdata == 32'h0;
	endproperty
	property p_rsvd;
		rd_st |=> prdata[31:15] == 17'h0;
	endproperty
	property p_lines;
		rd_st && hold > 5'h13 |=> prdata[14:13] == last_lines;
	endproperty
	property p_anak;
		s_ev(addr_nak_evt) |=> prdata[4];
	endproperty
	property p_dnak;
		s_ev(data_nak_evt) |=> prdata[7];
	endproperty
	property p_arbitration_lost_flag;
		s_ev(arb_lost_evt) |=> prdata[5];
	endproperty
	property p_master_engine_busy;
		rd_st && !master_clk_en |=> !prdata[6];
	endproperty
	property p_lvl;
		rd_st |=> prdata[1] == $past(tx_byte_valid);
	endproperty
	property p_txreq;
		rd_st && master_clk_en && (engine_dir_read || !tx_byte_valid)
			|=> prdata[2] == !$past(engine_dir_read);
	endproperty
	a_rdy: assert property (p_rdy) else $error("ready timing");
	a_err: assert property (p_err) else $error("unmapped access");
	a_rsvd: assert property (p_rsvd) else $error("reserved bits");
	a_lines: assert property (p_lines) else $error("line levels");
	a_anak: assert property (p_anak) else $error("address nak");
	a_dnak: assert property (p_dnak) else $error("data nak");
	a_arbitration_lost_flag: assert property (p_arbitration_lost_flag) else $error("arbitration");
	a_master_engine_busy: assert property (p_master_engine_busy) else $error("busy when off");
	a_lvl: assert property (p_lvl) else $error("fifo level");
	a_txreq: assert property (p_txreq) else $error("tx request");
endmodule : i2cm_status_props

bind i2cm_status i2cm_status_props u_props (.ref_clk, .rst_n, .psel, .penable,
	.pwrite, .paddr, .prdata, .pready, .pslverr, .scl_in, .sda_in, .engine_dir_read,
	.addr_nak_evt, .data_nak_evt, .arb_lost_evt, .tx_byte_valid, .master_clk_en);

`default_nettype wire

// ==== testbench/i2cm_bus_model.sv ====
// Purpose: Far side of the bus making starts and stops
// Assumes: Link clock of 125 ns, unrelated to ref_clk
// Notes: Lines move only inside a frame
`default_nettype none

module i2cm_bus_model (
	output logic scl,
	output logic sda
);
	timeunit 1ns;
	timeprecision 100ps;
	logic lclk;
	// Pull-ups hold both lines high while nobody drives
	initial begin
		scl = 1'b1;
		sda = 1'b1;
		lclk = 1'b0;
		#1.3;
		forever #62.5 lclk = ~lclk;
	end
	task automatic start();
		@(posedge lclk) sda <= 1'b0;
		@(posedge lclk) scl <= 1'b0;
	endtask : start
	task automatic stop();
		@(posedge lclk) sda <= 1'b0;
		@(posedge lclk) scl <= 1'b1;
		@(posedge lclk) sda <= 1'b1;
	endtask : stop
endmodule : i2cm_bus_model

`default_nettype wire

// ==== testbench/i2cm_status_tb.sv ====
// Purpose: Self-checking bench for the status block
// Assumes: Zero-wait APB slave, bus model on the lines
// Notes: Bytes come from a fixed-seed xorshift
`default_nettype none

module i2cm_status_tb;
	timeunit 1ns;
	timeprecision 100ps;
	`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fails++; \
		$display("[ERR] %0t got %h exp %h", $time, a, e); end end
	logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, err;
	logic engine_busy, engine_dir_read, tx_pop, rx_push, tx_byte_valid, master_clk_en;
	logic scl, sda;
	logic [4:0] evt;
	logic [7:0] rx_byte, tx_byte, b0, d;
	logic [31:0] paddr, pwdata, prdata, q;
	logic [31:0] seed = 32'h64b0;
	int fails, compares;
	int eb[5] = '{4, 7, 5, 11, 12};
	localparam logic [31:0] ST = i2cm_pkg::ADDR_STATUS;
	localparam logic [31:0] CT = i2cm_pkg::ADDR_CTRL;

	i2cm_status dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .scl_in(scl), .sda_in(sda),
		.engine_busy(engine_busy), .engine_dir_read(engine_dir_read),
		.addr_nak_evt(evt[0]), .data_nak_evt(evt[1]), .arb_lost_evt(evt[2]),
		.own_stop_evt(evt[3]), .tx_empty_end_evt(evt[4]), .tx_pop(tx_pop),
		.tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid), .rx_push(rx_push),
		.rx_byte(rx_byte), .master_clk_en(master_clk_en), .irq(irq));
	i2cm_bus_model bus (.scl(scl), .sda(sda));

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : rnd
	function automatic logic [1:0] lvl(input int n);
		return n == 1 ? i2cm_pkg::LVL_ONE : i2cm_pkg::LVL_FULL;
	endfunction : lvl
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : tick
	// Idle cycle first, so back-to-back calls never drive psel twice at one edge
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] wd);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) fails++;
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic pulse_evt(input logic [4:0] v);
		evt <= v;
		@(posedge ref_clk);
		evt <= 5'h0;
	endtask : pulse_evt
	task automatic test_done();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : test_done

	initial begin
		#100000;
		fails++;
		test_done();
	end

	initial begin
		{psel, penable, pwrite, engine_busy, engine_dir_read, tx_pop, rx_push} = '0;
		evt = 5'h0;
		paddr = 32'h0;
		pwdata = 32'h0;
		rx_byte = 8'h0;
		rst_n = 1'b0;
		tick(3);
		rst_n <= 1'b1;
		apb(1'b0, ST, 32'h0);
		`CHK(q & 32'hfffffffb, {16'h0, i2cm_pkg::RST_STATUS})
		`CHK(irq, 1'b0)
		apb(1'b0, 32'h4000_3480, 32'h0);
		`CHK({err, q}, 33'h1_0000_0000)
		$display("test reset done");
		apb(1'b1, CT, 32'h1f1);
		tick(1);
		`CHK(master_clk_en, 1'b1)
		`CHK(irq, 1'b1)
		for (int i = 0; i < 5; i++) begin
			pulse_evt(5'(1 << i));
			apb(1'b0, ST, 32'h0);
			`CHK(q[eb[i]], 1'b1)
			apb(1'b0, ST, 32'h0);
			`CHK(q[eb[i]], 1'b0)
		end
		// Corner: a new event lands on the very edge of the clearing read
		pulse_evt(5'h1);
		fork
			apb(1'b0, ST, 32'h0);
			begin tick(2); pulse_evt(5'h1); end
		join
		apb(1'b0, ST, 32'h0);
		`CHK(q[4], 1'b1)
		$display("test events done");
		for (int k = 1; k <= 3; k++) begin
			d = rnd();
			if (k == 1) b0 = d;
			apb(1'b1, i2cm_pkg::ADDR_TX, {24'h0, d});
			apb(1'b0, ST, 32'h0);
			`CHK(q[1:0], lvl(k))
			`CHK(q[2], k == 1)
		end
		`CHK(tx_byte, b0)
		`CHK(tx_byte_valid, 1'b1)
		tx_pop <= 1'b1;
		@(posedge ref_clk);
		tx_pop <= 1'b0;
		engine_dir_read <= 1'b1;
		apb(1'b0, ST, 32'h0);
		`CHK(q[2:0], {1'b0, i2cm_pkg::LVL_ONE})
		$display("test transmit done");
		for (int k = 0; k < 3; k++) begin
			d = rnd();
			if (k == 0) b0 = d;
			rx_byte <= d;
			rx_push <= 1'b1;
			@(posedge ref_clk);
			rx_push <= 1'b0;
			apb(1'b0, ST, 32'h0);
			`CHK(q[9], k == 2)
			`CHK(q[3], 1'b1)
		end
		apb(1'b0, i2cm_pkg::ADDR_RX, 32'h0);
		`CHK(q[7:0], b0)
		$display("test receive done");
		apb(1'b1, CT, 32'h101);
		bus.start();
		tick(40);
		pulse_evt(5'h10);
		apb(1'b0, ST, 32'h0);
		`CHK(q[12:10], 3'b001)
		`CHK(irq, 1'b0)
		bus.stop();
		tick(40);
		`CHK(irq, 1'b1)
		apb(1'b0, ST, 32'h0);
		`CHK(q[11:8], 4'b0001)
		tick(1);
		`CHK(irq, 1'b0)
		$display("test bus done");
		engine_busy <= 1'b1;
		apb(1'b0, ST, 32'h0);
		`CHK(q[6], 1'b1)
		apb(1'b1, CT, 32'h0);
		tick(1);
		`CHK(master_clk_en, 1'b0)
		`CHK(irq, 1'b0)
		pulse_evt(5'h1f);
		apb(1'b0, ST, 32'h0);
		`CHK(q[15:0] & i2cm_pkg::RC_MASK, 16'h0)
		`CHK(q[6], 1'b0)
		$display("test disable done");
		test_done();
	end
endmodule : i2cm_status_tb

`default_nettype wire
